/* design/spps_pkg.sv */
package spps_pkg;

   // Register map.
   localparam logic [15:0] SERIAL_PIN_CTRL_ADDR  = 16'hff91;
   localparam logic [7:0]  SERIAL_PIN_CTRL_RESET = 8'hc0;
   localparam logic [7:0]  SERIAL_PIN_CTRL_WMASK = 8'h3f;
   localparam logic [7:0]  SERIAL_PIN_CTRL_RSVD  = 8'hc0;
   localparam logic [7:0]  UNMAPPED_READ         = 8'h00;

   // Field positions.
   localparam int CH1_RX_POLARITY_INV = 0;
   localparam int CH1_TX_POLARITY_INV = 1;
   localparam int CH2_RX_POLARITY_INV = 2;
   localparam int CH2_TX_POLARITY_INV = 3;
   localparam int CH1_TX_PIN_FUNC_SEL = 4;
   localparam int CH2_TX_PIN_FUNC_SEL = 5;

   // Synchroniser reset level for the receive pins and the transmit-pin readback (lines idle high).
   localparam logic [1:0] RX_SYNC_RESET = 2'h3;

endpackage

/* design/spps_rx_sync.sv */
`timescale 1ns/1ns
module spps_rx_sync (
   // Clock and reset.
   input  wire logic       i_mclk,
   input  wire logic       i_rstn,
   // Pin levels and synchronised levels.
   input  wire logic [1:0] i_pin,
   output logic      [1:0] o_sync
);

   logic [1:0] stage1;
   logic [1:0] stage2;

   // First stage is read only by the second stage.
   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         stage1 <= spps_pkg::RX_SYNC_RESET;
         stage2 <= spps_pkg::RX_SYNC_RESET;
      end else begin
         stage1 <= i_pin;
         stage2 <= stage1;
      end
   end

   assign o_sync = stage2;

endmodule

/* design/spps_top.sv */
// Operation
// - Reset loads control register with c0.
// - Top two bits read one, ignore writes.
// - Bit 5 selects channel-two transmit pin function.
// - Bit 4 selects channel-one transmit pin function.
// - Bit 3 inverts channel-two transmit data.
// - Bit 2 inverts channel-two receive data.
// - Bit 1 inverts channel-one transmit data.
// - Bit 0 inverts channel-one receive data.
// - Polarity changes reach the flopped outputs on the clock edge after the register updates.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
module spps_top (
   // Clock and reset.
   input  wire logic        i_mclk,
   input  wire logic        i_rstn,
   // Register port.
   input  wire logic [15:0] i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   // Serial channel side.
   input  wire logic        i_ch1_txd,
   input  wire logic        i_ch2_txd,
   output logic             o_ch1_rxd,
   output logic             o_ch2_rxd,
   // Port logic side.
   input  wire logic        i_port3_bit5_gpio_out,
   input  wire logic        i_port3_bit5_gpio_oe,
   input  wire logic        i_port4_bit2_gpio_out,
   input  wire logic        i_port4_bit2_gpio_oe,
   output logic             o_port3_bit5_gpio_in,
   output logic             o_port4_bit2_gpio_in,
   // Pins; output enables are low while the pin is driven.
   input  wire logic        i_ch1_tx_pin,
   output logic             o_ch1_tx_pin,
   output logic             o_ch1_tx_pin_oe_n,
   input  wire logic        i_ch2_tx_pin,
   output logic             o_ch2_tx_pin,
   output logic             o_ch2_tx_pin_oe_n,
   input  wire logic        i_ch1_rx_pin,
   input  wire logic        i_ch2_rx_pin
);

   ////////////////////////////////////////////////////////////////////////////////

   logic [7:0] serial_pin_ctrl;
   logic [7:0] next_serial_pin_ctrl;
   logic [7:0] next_rdata;
   logic [1:0] rx_sync;
   logic [1:0] tx_pin_sync;
   logic       hit;
   logic       ch1_sel;
   logic       ch2_sel;
   logic       next_ch1_tx_pin;
   logic       next_ch2_tx_pin;
   logic       next_ch1_oe_n;
   logic       next_ch2_oe_n;

   assign hit = (i_addr == spps_pkg::SERIAL_PIN_CTRL_ADDR);

   // Writable bits are stored, reserved bits are forced to one.
   assign next_serial_pin_ctrl = (i_wr && hit)
      ? ((i_wdata & spps_pkg::SERIAL_PIN_CTRL_WMASK) | spps_pkg::SERIAL_PIN_CTRL_RSVD)
      : serial_pin_ctrl;

   assign next_rdata = (i_rd && hit) ? (serial_pin_ctrl | spps_pkg::SERIAL_PIN_CTRL_RSVD)
                     : spps_pkg::UNMAPPED_READ;

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         serial_pin_ctrl <= spps_pkg::SERIAL_PIN_CTRL_RESET;
         o_rdata         <= spps_pkg::UNMAPPED_READ;
      end else begin
         serial_pin_ctrl <= next_serial_pin_ctrl;
         o_rdata         <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////

   spps_rx_sync u_rx_sync (
      .i_mclk (i_mclk),
      .i_rstn (i_rstn),
      .i_pin  ({i_ch2_rx_pin, i_ch1_rx_pin}),
      .o_sync (rx_sync)
   );

   spps_rx_sync u_tx_pin_sync (
      .i_mclk (i_mclk),
      .i_rstn (i_rstn),
      .i_pin  ({i_ch2_tx_pin, i_ch1_tx_pin}),
      .o_sync (tx_pin_sync)
   );

   ////////////////////////////////////////////////////////////////////////////////

   assign ch1_sel = serial_pin_ctrl[spps_pkg::CH1_TX_PIN_FUNC_SEL];
   assign ch2_sel = serial_pin_ctrl[spps_pkg::CH2_TX_PIN_FUNC_SEL];

   // Transmit pins: serial data xor polarity, or the port bit. The only flop is the
   // output flop that every top output needs; the xor itself adds nothing. Software must
   // select the serial function before enabling its transmitter.
   assign next_ch1_tx_pin = ch1_sel
      ? (i_ch1_txd ^ serial_pin_ctrl[spps_pkg::CH1_TX_POLARITY_INV])
      : i_port3_bit5_gpio_out;
   assign next_ch2_tx_pin = ch2_sel
      ? (i_ch2_txd ^ serial_pin_ctrl[spps_pkg::CH2_TX_POLARITY_INV])
      : i_port4_bit2_gpio_out;
   assign next_ch1_oe_n = ch1_sel ? 1'h0 : !i_port3_bit5_gpio_oe;
   assign next_ch2_oe_n = ch2_sel ? 1'h0 : !i_port4_bit2_gpio_oe;

   always_ff @(posedge i_mclk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_ch1_tx_pin         <= 1'h1;
         o_ch2_tx_pin         <= 1'h1;
         o_ch1_tx_pin_oe_n    <= 1'h1;
         o_ch2_tx_pin_oe_n    <= 1'h1;
         o_ch1_rxd            <= 1'h1;
         o_ch2_rxd            <= 1'h1;
         o_port3_bit5_gpio_in <= 1'h1;
         o_port4_bit2_gpio_in <= 1'h1;
      end else begin
         o_ch1_tx_pin         <= next_ch1_tx_pin;
         o_ch2_tx_pin         <= next_ch2_tx_pin;
         o_ch1_tx_pin_oe_n    <= next_ch1_oe_n;
         o_ch2_tx_pin_oe_n    <= next_ch2_oe_n;
         // Receive inversion; the polarity bit acts on the next edge. Software changes
         // it only while the receiver ignores the line.
         o_ch1_rxd <= rx_sync[0] ^ serial_pin_ctrl[spps_pkg::CH1_RX_POLARITY_INV];
         o_ch2_rxd <= rx_sync[1] ^ serial_pin_ctrl[spps_pkg::CH2_RX_POLARITY_INV];
         o_port3_bit5_gpio_in <= tx_pin_sync[0];
         o_port4_bit2_gpio_in <= tx_pin_sync[1];
      end
   end

endmodule

/* test/spps_monitor.sv */
`timescale 1ns/1ns
module spps_monitor (
   // Clock and reset.
   input wire logic        i_mclk,
   input wire logic        i_rstn,
   // Register port.
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [15:0] i_addr,
   input wire logic [7:0]  i_wdata,
   input wire logic [7:0]  o_rdata,
   // Serial side.
   input wire logic        i_ch1_txd,
   input wire logic        i_ch2_txd,
   input wire logic        o_ch1_rxd,
   input wire logic        o_ch2_rxd,
   // Port logic side.
   input wire logic        i_port3_bit5_gpio_out,
   input wire logic        i_port3_bit5_gpio_oe,
   input wire logic        i_port4_bit2_gpio_out,
   input wire logic        i_port4_bit2_gpio_oe,
   // Pin side.
   input wire logic        i_ch1_rx_pin,
   input wire logic        i_ch2_rx_pin,
   input wire logic        o_ch1_tx_pin,
   input wire logic        o_ch2_tx_pin,
   input wire logic        o_ch1_tx_pin_oe_n,
   input wire logic        o_ch2_tx_pin_oe_n
);
   logic [7:0] r;
   wire        hit = i_addr == spps_pkg::SERIAL_PIN_CTRL_ADDR;
   wire        x1 = i_ch1_txd ^ r[1];
   wire        x2 = i_ch2_txd ^ r[3];
   // Shadow of the control register as software wrote it.
   always_ff @(posedge i_mclk or negedge i_rstn)
      if (!i_rstn) r <= 8'hc0;
      else if (i_wr && hit) r <= i_wdata | 8'hc0;
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rstn);
   a_read_value: assert property (i_rd && hit |=> o_rdata == $past(r))
      else $error("bad read");
   a_top_ones: assert property (i_rd && hit |=> o_rdata[7:6] == 2'h3)
      else $error("bad top bits");
   a_unmapped_zero: assert property (i_rd && !hit |=> o_rdata == 8'h00)
      else $error("bad unmapped read");
   a_ch1_tx_path: assert property (
      r[4] |=> !o_ch1_tx_pin_oe_n && o_ch1_tx_pin == $past(x1)) else $error("bad ch1 tx");
   a_ch2_tx_path: assert property (
      r[5] |=> !o_ch2_tx_pin_oe_n && o_ch2_tx_pin == $past(x2)) else $error("bad ch2 tx");
   a_ch1_port_pin: assert property (
      !r[4] |=> o_ch1_tx_pin_oe_n == !$past(i_port3_bit5_gpio_oe)) else $error("bad port");
   a_ch2_port_pin: assert property (
      !r[5] |=> o_ch2_tx_pin_oe_n == !$past(i_port4_bit2_gpio_oe)) else $error("bad ch2 port");
   a_ch1_port_data: assert property (
      i_rstn && !r[4] |=> o_ch1_tx_pin == $past(i_port3_bit5_gpio_out))
      else $error("bad ch1 port data");
   a_ch2_port_data: assert property (
      i_rstn && !r[5] |=> o_ch2_tx_pin == $past(i_port4_bit2_gpio_out))
      else $error("bad ch2 port data");
   a_ch1_rx_path: assert property (
      o_ch1_rxd == ($past(i_ch1_rx_pin, 3) ^ $past(r[0]))) else $error("bad ch1 rx");
   a_ch2_rx_path: assert property (
      o_ch2_rxd == ($past(i_ch2_rx_pin, 3) ^ $past(r[2]))) else $error("bad ch2 rx");
endmodule
bind spps_top spps_monitor u_mon (.i_mclk, .i_rstn, .i_wr, .i_rd, .i_addr, .i_wdata, .o_rdata,
   .i_ch1_txd, .i_ch2_txd, .o_ch1_rxd, .o_ch2_rxd, .i_ch1_rx_pin, .i_ch2_rx_pin, .o_ch1_tx_pin,
   .i_port3_bit5_gpio_out, .i_port3_bit5_gpio_oe, .i_port4_bit2_gpio_out,
   .i_port4_bit2_gpio_oe, .o_ch2_tx_pin, .o_ch1_tx_pin_oe_n, .o_ch2_tx_pin_oe_n);

/* test/spps_peer.sv */
`timescale 1ns/1ns
module spps_peer (
   // Transmit lines seen at the pads.
   input  wire logic i_ch1_line,
   input  wire logic i_ch2_line,
   // Receive pins towards the block.
   output logic      o_ch1_rx_pin,
   output logic      o_ch2_rx_pin
);
   // The far device echoes each transmit line on the matching receive line.
   assign o_ch1_rx_pin = i_ch1_line;
   assign o_ch2_rx_pin = i_ch2_line;
endmodule

/* test/serial_pin_polarity_select_tb.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
   $display("MISMATCH %0t %h %h", $time, a, b); end end
module serial_pin_polarity_select_tb;
   logic        i_mclk = 0, i_rstn = 0, i_wr = 0, i_rd = 0, t1 = 0, t2 = 0, g_out = 1, g_oe = 0;
   logic [15:0] i_addr = 16'h0000;
   logic [7:0]  i_wdata = 8'h00, o_rdata, v;
   logic        o1, o2, e1, e2, r1, r2, p1, p2, gi3, gi4;
   int          n_fail = 0, tests_run = 0;
   // A released pad is pulled up.
   wire         l1 = e1 ? 1'b1 : o1;
   wire         l2 = e2 ? 1'b1 : o2;
   spps_top DUT (.i_mclk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_ch1_txd(t1),
      .i_ch2_txd(t2), .o_ch1_rxd(r1), .o_ch2_rxd(r2), .i_port3_bit5_gpio_out(g_out),
      .i_port3_bit5_gpio_oe(g_oe), .i_port4_bit2_gpio_out(!g_out), .i_port4_bit2_gpio_oe(g_oe),
      .o_port3_bit5_gpio_in(gi3), .o_port4_bit2_gpio_in(gi4), .i_ch1_tx_pin(l1),
      .o_ch1_tx_pin(o1), .o_ch1_tx_pin_oe_n(e1), .i_ch2_tx_pin(l2), .o_ch2_tx_pin(o2),
      .o_ch2_tx_pin_oe_n(e2), .i_ch1_rx_pin(p1), .i_ch2_rx_pin(p2));
   spps_peer peer (.i_ch1_line(l1), .i_ch2_line(l2), .o_ch1_rx_pin(p1), .o_ch2_rx_pin(p2));
   initial forever #4 i_mclk = ~i_mclk;
   task automatic cyc(int n);
      repeat (n) @(posedge i_mclk);
   endtask
   task automatic wr(logic [15:0] a, logic [7:0] d);
      @(posedge i_mclk); i_wr <= 1; i_addr <= a; i_wdata <= d;
      @(posedge i_mclk); i_wr <= 0;
   endtask
   task automatic rd(logic [15:0] a, logic [7:0] x);
      @(posedge i_mclk); i_rd <= 1; i_addr <= a;
      @(posedge i_mclk); i_rd <= 0;
      #1 `CHK(o_rdata, x)
   endtask
   task automatic t_reg;
      rd(16'hff91, 8'hc0);
      rd(16'hff90, 8'h00);
      wr(16'hff91, 8'h00); rd(16'hff91, 8'hc0);
      wr(16'hff91, 8'hff); rd(16'hff91, 8'hff);
      $display("register test done");
   endtask
   // Transmit data is set before each select write, as software must do.
   task automatic t_path;
      for (int i = 0; i < 16; i++) begin
         @(posedge i_mclk);
         v = 8'h30 | i[3:0];
         t1 <= i[2];
         t2 <= i[0];
         wr(16'hff91, v);
         cyc(5); #1
         `CHK({e1, e2}, 2'h0)
         `CHK(o1, t1 ^ v[1])
         `CHK(o2, t2 ^ v[3])
         `CHK(r1, t1 ^ v[1] ^ v[0])
         `CHK(r2, t2 ^ v[3] ^ v[2])
      end
      $display("path test done");
   endtask
   task automatic t_gpio;
      @(posedge i_mclk);
      g_oe <= 1;
      g_out <= 0;
      wr(16'hff91, 8'h0f);
      cyc(5);
      #1 `CHK({e1, e2, o1, o2, gi3, gi4}, 6'h05)
      @(posedge i_mclk);
      g_oe <= 0;
      g_out <= 1;
      cyc(5);
      #1 `CHK({e1, e2, o1, o2, gi3, gi4}, 6'h3b)
      $display("port test done");
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      cyc(5); i_rstn <= 1;
      t_reg; t_path; t_gpio; wrap_up;
   end
endmodule
